// file: logic/regulator_control_pkg.sv
// Register map, field layout and reset values of the regulator control bank.
// Assumes an 8-bit register port driven by the serial interface decoder.
package regulator_control_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] first_converter_limits_addr = 8'h03;
  localparam logic [7:0] second_converter_control_addr = 8'h04;
  localparam logic [7:0] second_converter_limits_addr = 8'h05;
  localparam logic [7:0] first_converter_voltage_addr = 8'h06;
  localparam logic [7:0] second_converter_voltage_addr = 8'h07;
  localparam logic [7:0] first_linear_control_addr = 8'h08;
  localparam logic [7:0] second_linear_control_addr = 8'h09;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int limit_lsb = 3;
  localparam int ramp_lsb = 0;
  localparam int force_fixed_freq_bit = 3;
  localparam int discharge_bit = 2;
  localparam int pin_qualified_bit = 1;
  localparam int enable_bit = 0;

  // ---------------------------------------------------------------
  // Reset values (undefined fields reset to zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] limits_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h04;
  localparam logic [7:0] voltage_reset = 8'h00;

  // ---------------------------------------------------------------
  // Reserved codes
  // ---------------------------------------------------------------
  localparam logic [2:0] limit_max_code = 3'h5;
  localparam logic [2:0] ramp_min_code = 3'h2;
  localparam logic [7:0] voltage_min_code = 8'h14;

  // Decoded controls of one regulator, towards the sequencing logic
  typedef struct packed {
    logic enable;
    logic discharge_on;
    logic force_fixed_freq;
  } reg_ctrl_t;

  // Converter settings
  typedef struct packed {
    logic [2:0] current_limit;
    logic [2:0] ramp_rate;
    logic [7:0] voltage_code;
    logic code_reserved;
  } conv_set_t;

endpackage

// file: logic/regulator_enable_gate.sv
// Combines a register enable with the external enable pin.
// Assumes the pin level is already synchronised to CLK.
`timescale 1ns/10ps
`default_nettype none
module regulator_enable_gate (
  // Control bits
  input wire logic enable,
  input wire logic pin_qualified,
  // Synchronised pin
  input wire logic pin_level,
  // Result
  output logic active
);
  assign active = enable & (~pin_qualified | pin_level);
endmodule
`default_nettype wire

// file: logic/regulator_control_regs.sv
// Configuration registers for two step-down converters and two linear
// regulators. Assumes the serial interface presents one-cycle write and read
// strobes with an 8-bit address on CLK.
//
// Contract
// - First converter limit field bits 5:3, codes 0-5 give 1.5-4.0 A.
// - New limit codes are accepted and applied while the converter runs.
// - First converter ramp field bits 2:0, codes 2-7, 0 and 1 reserved.
// - Second converter limit field uses the same encoding as the first.
// - Second converter ramp field uses the same mapping as the first.
// - Second converter control bit 3 forces fixed-frequency operation.
// - Second converter control bit 2 enables discharge, resets to one.
// - Second converter control bit 1 adds the enable pin to control.
// - Second converter control bit 0 enables the converter.
// - First converter 8-bit voltage code, codes below 0x14 reserved.
// - Second converter voltage code uses the identical mapping.
// - First linear control bit 2 enables discharge, resets to one.
// - First linear control bit 1 adds the enable pin to control.
// - First linear control bit 0 turns the regulator on.
// - Second linear control bits 2, 1, 0 mirror the first regulator.
`timescale 1ns/10ps
`default_nettype none
module regulator_control_regs (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic ADDR_HIT,
  // External enable pin
  input wire logic EN_PIN,
  // Converter controls
  output regulator_control_pkg::reg_ctrl_t CONV_A_CTRL,
  output regulator_control_pkg::reg_ctrl_t CONV_B_CTRL,
  output regulator_control_pkg::conv_set_t CONV_A_SET,
  output regulator_control_pkg::conv_set_t CONV_B_SET,
  // Linear regulator controls
  output regulator_control_pkg::reg_ctrl_t LIN_A_CTRL,
  output regulator_control_pkg::reg_ctrl_t LIN_B_CTRL
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Reserved bits are kept and read back as written.
  logic [7:0] first_converter_limits;
  logic [7:0] second_converter_control;
  logic [7:0] second_converter_limits;
  logic [7:0] first_converter_voltage;
  logic [7:0] second_converter_voltage;
  logic [7:0] first_linear_control;
  logic [7:0] second_linear_control;
  logic pin_meta;
  logic pin_level;
  logic conv_b_active;
  logic lin_a_active;
  logic lin_b_active;
  logic hit;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_meta <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_meta <= EN_PIN;
      pin_level <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // Converter limit registers
  // ---------------------------------------------------------------
  // No enable interlock: a limit write takes effect on the next edge.
  always_ff @(posedge CLK) begin
    if (RST) begin
      first_converter_limits <= regulator_control_pkg::limits_reset;
      second_converter_limits <= regulator_control_pkg::limits_reset;
    end else if (WR_STB) begin
      if (ADDR == regulator_control_pkg::first_converter_limits_addr) begin
        first_converter_limits <= WDATA;
      end
      if (ADDR == regulator_control_pkg::second_converter_limits_addr) begin
        second_converter_limits <= WDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // Voltage registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      first_converter_voltage <= regulator_control_pkg::voltage_reset;
      second_converter_voltage <= regulator_control_pkg::voltage_reset;
    end else if (WR_STB) begin
      if (ADDR == regulator_control_pkg::first_converter_voltage_addr) begin
        first_converter_voltage <= WDATA;
      end
      if (ADDR == regulator_control_pkg::second_converter_voltage_addr) begin
        second_converter_voltage <= WDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      second_converter_control <= regulator_control_pkg::control_reset;
      first_linear_control <= regulator_control_pkg::control_reset;
      second_linear_control <= regulator_control_pkg::control_reset;
    end else if (WR_STB) begin
      if (ADDR == regulator_control_pkg::second_converter_control_addr) begin
        second_converter_control <= WDATA;
      end
      if (ADDR == regulator_control_pkg::first_linear_control_addr) begin
        first_linear_control <= WDATA;
      end
      if (ADDR == regulator_control_pkg::second_linear_control_addr) begin
        second_linear_control <= WDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    case (ADDR)
      regulator_control_pkg::first_converter_limits_addr,
      regulator_control_pkg::second_converter_control_addr,
      regulator_control_pkg::second_converter_limits_addr,
      regulator_control_pkg::first_converter_voltage_addr,
      regulator_control_pkg::second_converter_voltage_addr,
      regulator_control_pkg::first_linear_control_addr,
      regulator_control_pkg::second_linear_control_addr: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign ADDR_HIT = hit;

  // Unmapped addresses read as zero so the bank can share a bus.
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else begin
      RVALID <= RD_STB;
      if (RD_STB) begin
        case (ADDR)
          regulator_control_pkg::first_converter_limits_addr:
            RDATA <= first_converter_limits;
          regulator_control_pkg::second_converter_control_addr:
            RDATA <= second_converter_control;
          regulator_control_pkg::second_converter_limits_addr:
            RDATA <= second_converter_limits;
          regulator_control_pkg::first_converter_voltage_addr:
            RDATA <= first_converter_voltage;
          regulator_control_pkg::second_converter_voltage_addr:
            RDATA <= second_converter_voltage;
          regulator_control_pkg::first_linear_control_addr:
            RDATA <= first_linear_control;
          regulator_control_pkg::second_linear_control_addr:
            RDATA <= second_linear_control;
          default:
            RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Enable qualification
  // ---------------------------------------------------------------
  regulator_enable_gate u_gate_conv_b (
    .enable(second_converter_control[regulator_control_pkg::enable_bit]),
    .pin_qualified(
      second_converter_control[regulator_control_pkg::pin_qualified_bit]),
    .pin_level(pin_level),
    .active(conv_b_active)
  );

  regulator_enable_gate u_gate_lin_a (
    .enable(first_linear_control[regulator_control_pkg::enable_bit]),
    .pin_qualified(
      first_linear_control[regulator_control_pkg::pin_qualified_bit]),
    .pin_level(pin_level),
    .active(lin_a_active)
  );

  regulator_enable_gate u_gate_lin_b (
    .enable(second_linear_control[regulator_control_pkg::enable_bit]),
    .pin_qualified(
      second_linear_control[regulator_control_pkg::pin_qualified_bit]),
    .pin_level(pin_level),
    .active(lin_b_active)
  );

  // ---------------------------------------------------------------
  // Outputs to the regulators
  // ---------------------------------------------------------------
  // The first converter's control register lies outside this bank.
  assign CONV_A_CTRL = '0;

  assign CONV_B_CTRL.enable = conv_b_active;
  assign CONV_B_CTRL.discharge_on =
    second_converter_control[regulator_control_pkg::discharge_bit] &
    ~conv_b_active;
  assign CONV_B_CTRL.force_fixed_freq =
    second_converter_control[regulator_control_pkg::force_fixed_freq_bit];

  assign LIN_A_CTRL.enable = lin_a_active;
  assign LIN_A_CTRL.discharge_on =
    first_linear_control[regulator_control_pkg::discharge_bit] &
    ~lin_a_active;
  assign LIN_A_CTRL.force_fixed_freq = 1'b0;

  assign LIN_B_CTRL.enable = lin_b_active;
  assign LIN_B_CTRL.discharge_on =
    second_linear_control[regulator_control_pkg::discharge_bit] &
    ~lin_b_active;
  assign LIN_B_CTRL.force_fixed_freq = 1'b0;

  // Reserved codes are flagged, not blocked; software must avoid them.
  assign CONV_A_SET.current_limit =
    first_converter_limits[regulator_control_pkg::limit_lsb +: 3];
  assign CONV_A_SET.ramp_rate =
    first_converter_limits[regulator_control_pkg::ramp_lsb +: 3];
  assign CONV_A_SET.voltage_code = first_converter_voltage;
  assign CONV_A_SET.code_reserved =
    (CONV_A_SET.current_limit > regulator_control_pkg::limit_max_code) |
    (CONV_A_SET.ramp_rate < regulator_control_pkg::ramp_min_code) |
    (first_converter_voltage < regulator_control_pkg::voltage_min_code);

  assign CONV_B_SET.current_limit =
    second_converter_limits[regulator_control_pkg::limit_lsb +: 3];
  assign CONV_B_SET.ramp_rate =
    second_converter_limits[regulator_control_pkg::ramp_lsb +: 3];
  assign CONV_B_SET.voltage_code = second_converter_voltage;
  assign CONV_B_SET.code_reserved =
    (CONV_B_SET.current_limit > regulator_control_pkg::limit_max_code) |
    (CONV_B_SET.ramp_rate < regulator_control_pkg::ramp_min_code) |
    (second_converter_voltage < regulator_control_pkg::voltage_min_code);

endmodule
`default_nettype wire

// file: tb/regulator_control_regs_properties.sv
// Port-level checks of the regulator control bank.
// Assumes it is bound to the bank and sees only its top ports.
`timescale 1ns/10ps
`default_nettype none
module regulator_control_regs_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic RVALID,
  input wire logic ADDR_HIT,
  input wire logic EN_PIN,
  // Regulator controls
  input wire regulator_control_pkg::reg_ctrl_t CONV_A_CTRL,
  input wire regulator_control_pkg::reg_ctrl_t CONV_B_CTRL,
  input wire regulator_control_pkg::conv_set_t CONV_A_SET,
  input wire regulator_control_pkg::conv_set_t CONV_B_SET,
  input wire regulator_control_pkg::reg_ctrl_t LIN_A_CTRL,
  input wire regulator_control_pkg::reg_ctrl_t LIN_B_CTRL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_read_answer: assert property (RD_STB |=> RVALID ##1 !RVALID)
    else $error("read answer missing or too long");
  a_limit_a_apply: assert property (
    WR_STB && ADDR == 8'h03 |=> CONV_A_SET[14:9] == $past(WDATA[5:0]))
    else $error("first converter limits not applied");
  a_limit_b_apply: assert property (
    WR_STB && ADDR == 8'h05 |=> CONV_B_SET[14:9] == $past(WDATA[5:0]))
    else $error("second converter limits not applied");
  a_vcode_a_apply: assert property (
    WR_STB && ADDR == 8'h06 |=> CONV_A_SET.voltage_code == $past(WDATA))
    else $error("first converter voltage not applied");
  a_reserved_flag: assert property (CONV_B_SET.code_reserved ==
    (CONV_B_SET[14:12] > 3'h5 || CONV_B_SET[11:9] < 3'h2 ||
    CONV_B_SET.voltage_code < 8'h14))
    else $error("reserved code flag wrong");
  a_mode_b_apply: assert property (
    WR_STB && ADDR == 8'h04 |=>
    CONV_B_CTRL.force_fixed_freq == $past(WDATA[3]))
    else $error("mode bit not applied");
  a_discharge_idle: assert property ($fell(RST) |->
    CONV_B_CTRL.discharge_on && LIN_A_CTRL.discharge_on &&
    LIN_B_CTRL.discharge_on)
    else $error("discharge not on after reset");
  a_pin_rise_cause: assert property (
    $rose(LIN_A_CTRL.enable) && !$past(WR_STB) |-> $past(EN_PIN, 2))
    else $error("enable rose without pin");
  a_unmapped_zero: assert property (RD_STB && !ADDR_HIT |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  c_unmapped: cover property (RD_STB && !ADDR_HIT);
  c_limit_b: cover property (WR_STB && ADDR == 8'h05);
  c_pin_rise: cover property ($rose(LIN_A_CTRL.enable) && !$past(WR_STB));
endmodule
`default_nettype wire

// file: tb/tb_regulator_control_regs.sv
// Self-checking bench for the regulator control bank.
// Assumes the package is compiled first; drives inputs on falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_regulator_control_regs;
  logic CLK, RST, WR_STB, RD_STB, EN_PIN, RVALID, ADDR_HIT, en;
  logic [7:0] ADDR, WDATA, RDATA, a, v;
  logic [7:0] um [3] = '{8'h02, 8'h0a, 8'hff};
  logic [7:0] vc [6] = '{8'h00, 8'h13, 8'h14, 8'h9d, 8'h9e, 8'hff};
  regulator_control_pkg::reg_ctrl_t CONV_A_CTRL, CONV_B_CTRL, c;
  regulator_control_pkg::reg_ctrl_t LIN_A_CTRL, LIN_B_CTRL;
  regulator_control_pkg::conv_set_t CONV_A_SET, CONV_B_SET;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  regulator_control_regs dut (.CLK, .RST, .WR_STB, .RD_STB, .ADDR, .WDATA,
    .RDATA, .RVALID, .ADDR_HIT, .EN_PIN, .CONV_A_CTRL, .CONV_B_CTRL,
    .CONV_A_SET, .CONV_B_SET, .LIN_A_CTRL, .LIN_B_CTRL);
  // ---------------------------------------------------------------
  // Clock, timeout and access tasks
  // ---------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // Whole run needs about 510 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge CLK);
    WR_STB = 1'b1;
    ADDR = ad;
    WDATA = d;
    @(negedge CLK);
    WR_STB = 1'b0;
  endtask
  // Answer stands one cycle, so it is looked at on the next falling edge
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge CLK);
    RD_STB = 1'b1;
    ADDR = ad;
    @(negedge CLK);
    RD_STB = 1'b0;
    chk({7'h0, RVALID, RDATA}, {8'h01, exp});
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    RST = 1'b1;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    EN_PIN = 1'b0;
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    for (int i = 3; i < 10; i++) begin
      rd(8'(i), (i == 4 || i > 7) ? 8'h04 : 8'h00);
    end
    chk(16'({CONV_A_CTRL, CONV_B_CTRL, LIN_A_CTRL, LIN_B_CTRL}),
      16'h092);
    wr(8'h0a, 8'h5a);
    foreach (um[k]) begin
      rd(um[k], 8'h00);
      chk(16'(ADDR_HIT), 16'h0);
    end
    wr(8'h06, 8'h14);
    wr(8'h07, 8'h14);
    wr(8'h04, 8'h01);
    for (int i = 0; i < 16; i++) begin
      a = i[3] ? 8'h05 : 8'h03;
      v = {i[1:0], i[2:0], 3'(7 - i)};
      wr(a, v);
      c = 3'b000;
      chk(16'(i[3] ? CONV_B_SET : CONV_A_SET),
        {1'b0, v[5:0], 8'h14,
        v[5:3] > 3'h5 || v[2:0] < 3'h2});
      rd(a, v);
      chk(16'(CONV_B_CTRL.enable), 16'h1);
    end
    wr(8'h05, 8'h2b);
    foreach (vc[k]) begin
      wr(8'h07, vc[k]);
      chk({CONV_B_SET.voltage_code, 7'h0, CONV_B_SET.code_reserved},
        {vc[k], 7'h0, vc[k] < 8'h14});
    end
    // Pin is changed four edges ahead of the check so the synchroniser has settled
    for (int i = 0; i < 96; i++) begin
      a = (i < 32) ? 8'h04 : (i < 64) ? 8'h08 : 8'h09;
      v = {4'h0, i[3:0]};
      EN_PIN = i[4];
      wr(a, v);
      repeat (2) @(negedge CLK);
      c = (a == 8'h04) ? CONV_B_CTRL : (a == 8'h08) ? LIN_A_CTRL : LIN_B_CTRL;
      en = v[0] & (~v[1] | i[4]);
      chk(16'(c), {13'h0, en, v[2] & ~en,
        v[3] & (a == 8'h04)});
    end
    EN_PIN = 1'b0;
    wr(8'h08, 8'h03);
    repeat (3) @(negedge CLK);
    chk(16'(LIN_A_CTRL.enable), 16'h0);
    EN_PIN = 1'b1;
    repeat (3) @(negedge CLK);
    chk(16'(LIN_A_CTRL.enable), 16'h1);
    RST = 1'b1;
    @(negedge CLK);
    RST = 1'b0;
    rd(8'h05, 8'h00);
    rd(8'h09, 8'h04);
    end_sim;
  end
endmodule
bind regulator_control_regs regulator_control_regs_properties chk_i (.CLK,
  .RST, .WR_STB, .RD_STB, .ADDR, .WDATA, .RDATA, .RVALID, .ADDR_HIT, .EN_PIN,
  .CONV_A_CTRL, .CONV_B_CTRL, .CONV_A_SET, .CONV_B_SET, .LIN_A_CTRL,
  .LIN_B_CTRL);
`default_nettype wire
